// ### rtl/cra_channel_regs.sv
// Purpose: per-channel register bank with multibyte holding registers
// Assumes: host accesses arrive one byte at a time from the serial port
// Notes: EEPROM answer is expected one clock after its read strobe
`timescale 1ns/10ps
module cra_channel_regs #(
    parameter logic [7:0] ID_LOW = 8'h5A,  // Arbitrary value
    parameter logic [7:0] ID_HIGH = 8'h01  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial host port
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // EEPROM bank
    input wire logic [7:0] ee_rdata,
    output cra_pkg::cra_ee_t ee,
    // Status from the clocking logic
    input wire cra_pkg::cra_stat_t st,
    // Control to the clocking logic
    output logic bank_select_bit,
    output logic [16:0][7:0] cfg_regs,
    output logic [39:0] writable_frequency_word,
    output logic [31:0] phase_offset_word
);
    import cra_pkg::*;

    cra_reg_t s_q, s_d;
    cra_req_t req;
    cra_mb_t mb;
    logic [39:0] live;
    logic [7:0] rdv;
    logic [3:0] clr;
    logic [2:0] last;
    logic int_now;

    ////////////////////////////////////////////////////////////////////////
    // Host port; the only way into this channel's registers
    cra_spi_port u_port (
        .clk(clk),
        .rst(rst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .rdata(s_q.rdata),
        .req(req)
    );

    ////////////////////////////////////////////////////////////////////////
    // Which multibyte field, and which byte of it, an address hits
    function automatic cra_mb_t mb_decode(input logic [10:0] a);
        cra_mb_t m;
        m = '0;
        if (a >= CRA_FZ_BASE && a <= CRA_FZ_BASE + CRA_FZ_SPAN) begin
            m.id = CRA_MB_FZ;
            m.idx = 3'(a - CRA_FZ_BASE);
        end else if (a >= CRA_PH_BASE && a <= CRA_PH_BASE + CRA_W32_SPAN) begin
            m.id = CRA_MB_PH;
            m.idx = 3'(a - CRA_PH_BASE);
        end else if (a >= CRA_MF_BASE && a <= CRA_MF_BASE + CRA_W32_SPAN) begin
            m.id = CRA_MB_MF;
            m.idx = 3'(a - CRA_MF_BASE);
        end else if (a >= CRA_PS_BASE && a <= CRA_PS_BASE + CRA_W32_SPAN) begin
            m.id = CRA_MB_PS;
            m.idx = 3'(a - CRA_PS_BASE);
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Single-byte read mux; anything not listed reads zero
    always_comb begin
        int_now = s_q.intie & ((|(s_q.lat & s_q.ie)) | (|st.int_src));
        rdv = 8'h00;
        case (req.addr)
            CRA_ID_LOW_ADDR: rdv = ID_LOW;
            CRA_ID_HIGH_ADDR: rdv = ID_HIGH;
            CRA_PINCFG_ADDR: rdv = st.cfg_pins;
            CRA_PINSR_ADDR: rdv = {4'h0, st.pin_levels};
            CRA_INTSUM_ADDR: rdv = {1'b0, st.int_src, s_q.intie, int_now};
            CRA_GLOB_ADDR: rdv = st.glob;
            CRA_ICSUM_ADDR: rdv = {5'h00, st.ic_sum};
            CRA_OCSUM_ADDR: rdv = {5'h00, st.oc_sum};
            CRA_ASUM_ADDR: rdv = {7'h00, st.apll_sum};
            CRA_DSUM_ADDR: rdv = {7'h00, st.dpll_sum};
            CRA_ALOCK_ADDR: rdv = {1'b0, s_q.ie[CRA_LAT_ALK2],
                s_q.lat[CRA_LAT_ALK2], st.alk2, st.adlk,
                s_q.ie[CRA_LAT_ALK], s_q.lat[CRA_LAT_ALK], st.alk};
            CRA_PRIO1_ADDR: rdv = st.prio1;
            CRA_PRIO2_ADDR: rdv = st.prio2;
            CRA_MSR1_ADDR: rdv = {1'b0, st.meas_ovfl, s_q.ie[CRA_LAT_RDY],
                s_q.lat[CRA_LAT_RDY], st.meas_busy, st.meas[10:8]};
            CRA_MSR2_ADDR: rdv = st.meas[7:0];
            CRA_PADJ_ADDR: rdv = {4'h0, s_q.ie[CRA_LAT_ADJ],
                s_q.lat[CRA_LAT_ADJ], st.pa_busy, st.pa_armed};
            default: rdv = 8'h00;
        endcase
        for (int i = 0; i < CRA_NCFG - 1; i++) begin
            if (req.addr == CRA_CFG_ADDR[i]) begin
                rdv = s_q.cfg[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access handling: one read holding is shared by every multibyte field and one write
    // holding by the two writable ones, so interleaved sequences corrupt each other
    always_comb begin
        s_d = s_q;
        clr = 4'h0;
        mb = mb_decode(req.addr);
        last = (mb.id == CRA_MB_FZ) ? CRA_FZ_LAST : CRA_W32_LAST;
        case (mb.id)
            CRA_MB_FZ: live = s_q.fword;
            CRA_MB_PH: live = {8'h00, s_q.pword};
            CRA_MB_MF: live = {8'h00, st.meas_measured_frequency_word};
            CRA_MB_PS: live = {8'h00, st.phase};
            default: live = 40'h00_0000_0000;
        endcase
        s_d.ee.we = 1'b0;
        s_d.ee.re = 1'b0;
        s_d.ee_pend = 1'b0;
        // EEPROM data returns one clock after its strobe
        if (s_q.ee_pend) begin
            s_d.rdata = ee_rdata;
        end
        if (req.rd || req.wr) begin
            if (req.addr == CRA_BANK_ADDR) begin
                // Reachable in either bank
                if (req.wr) begin
                    s_d.bank = req.wdata[0];
                end
                if (req.rd) begin
                    s_d.rdata = {7'h00, s_q.bank};
                end
            end else if (s_q.bank) begin
                // Upper space goes to the EEPROM instead
                s_d.ee.we = req.wr;
                s_d.ee.re = req.rd;
                s_d.ee.addr = req.addr;
                s_d.ee.wdata = req.wdata;
                s_d.ee_pend = req.rd;
            end else if (mb.id != CRA_MB_NONE) begin
                if (req.rd && mb.idx == 3'h0) begin
                    // First byte snapshots the live field
                    s_d.rd_hold = live;
                    s_d.rdata = live[7:0];
                end else if (req.rd) begin
                    s_d.rdata = s_q.rd_hold[{mb.idx, 3'b000} +: 8];
                end
                // Measured words are read only
                if (req.wr && (mb.id == CRA_MB_FZ || mb.id == CRA_MB_PH)) begin
                    s_d.rd_hold[{mb.idx, 3'b000} +: 8] = req.wdata;
                    // Live words move only here, on the top byte
                    if (mb.idx == last && mb.id == CRA_MB_FZ) begin
                        s_d.fword = {req.wdata, s_q.wr_hold[31:0]};
                    end else if (mb.idx == last) begin
                        s_d.pword = {req.wdata, s_q.wr_hold[23:0]};
                    end else begin
                        s_d.wr_hold[{mb.idx, 3'b000} +: 8] = req.wdata;
                    end
                end
            end else begin
                if (req.rd) begin
                    s_d.rdata = rdv;
                end
                if (req.wr) begin
                    // Only writable bits are touched
                    case (req.addr)
                        CRA_INTSUM_ADDR: begin
                            s_d.intie = req.wdata[CRA_INTIE_BIT];
                        end
                        CRA_ALOCK_ADDR: begin
                            s_d.ie[CRA_LAT_ALK2] = req.wdata[6];
                            s_d.ie[CRA_LAT_ALK] = req.wdata[2];
                            clr[CRA_LAT_ALK2] = req.wdata[5];
                            clr[CRA_LAT_ALK] = req.wdata[1];
                        end
                        CRA_MSR1_ADDR: begin
                            s_d.ie[CRA_LAT_RDY] = req.wdata[5];
                            clr[CRA_LAT_RDY] = req.wdata[4];
                        end
                        CRA_PADJ_ADDR: begin
                            s_d.ie[CRA_LAT_ADJ] = req.wdata[3];
                            clr[CRA_LAT_ADJ] = req.wdata[2];
                        end
                        default: clr = 4'h0;
                    endcase
                    for (int i = 0; i < CRA_NCFG - 1; i++) begin
                        if (req.addr == CRA_CFG_ADDR[i]) begin
                            s_d.cfg[i] = req.wdata;
                        end
                    end
                end
            end
        end
        // A new event wins over a clear in the same clock
        s_d.lat = (s_q.lat & ~clr) | st.ev;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.cfg <= {CRA_NCFG{CRA_CFG_RST}};
            s_q.ie <= CRA_IE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops
    assign ee = s_q.ee;
    assign bank_select_bit = s_q.bank;
    assign cfg_regs = s_q.cfg;
    assign writable_frequency_word = s_q.fword;
    assign phase_offset_word = s_q.pword;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic acc_reg, fz_low_wr, fz_top_wr, fz0_rd, fz1_rd, ph1_wr;
    assign acc_reg = !s_q.bank && req.addr != CRA_BANK_ADDR;
    assign fz_low_wr = acc_reg && req.wr && req.addr >= CRA_FZ_BASE
        && req.addr < CRA_FZ_BASE + CRA_FZ_SPAN;
    assign fz_top_wr = acc_reg && req.wr
        && req.addr == CRA_FZ_BASE + CRA_FZ_SPAN;
    assign fz0_rd = acc_reg && req.rd && req.addr == CRA_FZ_BASE;
    assign fz1_rd = acc_reg && req.rd && req.addr == CRA_FZ_BASE + 11'h001;
    assign ph1_wr = acc_reg && req.wr && req.addr == CRA_PH_BASE + 11'h001;

    // Top byte write, then the clock in which the commit must show
    sequence s_top_write;
        fz_top_wr ##1 1'b1;
    endsequence

    property p_low_hold;
        fz_low_wr |=> $stable(s_q.fword);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low byte hit live");

    property p_commit;
        s_top_write |-> s_q.fword
            == {$past(req.wdata), $past(s_q.wr_hold[31:0])};
    endproperty
    a_commit: assert property (p_commit)
        else $error("field not committed");

    property p_no_top;
        !fz_top_wr |=> $stable(s_q.fword);
    endproperty
    a_no_top: assert property (p_no_top)
        else $error("field moved");

    property p_snap;
        fz0_rd |=> s_q.rdata == $past(s_q.fword[7:0])
            && s_q.rd_hold == $past(s_q.fword);
    endproperty
    a_snap: assert property (p_snap)
        else $error("first read wrong");

    property p_hold_rd;
        fz1_rd |=> s_q.rdata == $past(s_q.rd_hold[15:8]);
    endproperty
    a_hold_rd: assert property (p_hold_rd)
        else $error("hold read wrong");

    property p_mid_read_wr;
        ph1_wr |=> s_q.rd_hold[15:8] == $past(req.wdata);
    endproperty
    a_mid_read_wr: assert property (p_mid_read_wr)
        else $error("hold not hit");

    property p_ee_route;
        (s_q.bank && (req.rd || req.wr) && req.addr != CRA_BANK_ADDR)
            |=> s_q.ee.re == $past(req.rd) && s_q.ee.we == $past(req.wr)
            && s_q.ee.addr == $past(req.addr);
    endproperty
    a_ee_route: assert property (p_ee_route)
        else $error("no EEPROM access");

    property p_bank;
        (req.wr && req.addr == CRA_BANK_ADDR)
            |=> s_q.bank == $past(req.wdata[0]);
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank not written");

    property p_w1c;
        (acc_reg && req.wr && req.addr == CRA_ALOCK_ADDR && req.wdata[1]
            && !st.ev[CRA_LAT_ALK]) |=> !s_q.lat[CRA_LAT_ALK];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("latched bit not cleared");

    property p_unmapped;
        (acc_reg && req.rd && req.addr[10:9] == 2'b11) |=> s_q.rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped not zero");

endmodule

// ### rtl/cra_pkg.sv
// Purpose: constants and types of the channel register access layer
// Assumes: one channel, byte-wide host accesses, 11-bit channel addresses
// Notes: the EEPROM bank itself lives outside this block
//
// Functional notes
// - Lower byte writes park in write holding
// - Top byte write commits whole field at once
// - No top byte write, field keeps value
// - Lowest byte read mid-write returns live field value
// - Lowest byte read snapshots field to read holding
// - Later byte reads come from read holding
// - Writes mid-read overwrite read holding bytes
// - One write and one read holding per channel
// - Forty-bit writable frequency word over five bytes
// - Bank bit selects registers or EEPROM above zero
// - Bank select always at address zero
// - Registers reached only through channel serial port
// - Latched status bits clear on written one
// - Read-only fields ignore writes
package cra_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Addresses
    localparam logic [10:0] CRA_BANK_ADDR = 11'h000;
    localparam int CRA_NCFG = 17;
    localparam logic [10:0] CRA_CFG_ADDR [0:16] = '{
        11'h009, 11'h00A, 11'h00B, 11'h00C, 11'h00D, 11'h00E, 11'h00F,
        11'h012, 11'h013, 11'h014, 11'h015, 11'h01B, 11'h01C, 11'h01D,
        11'h01E, 11'h01F, 11'h000};
    localparam logic [10:0] CRA_ID_LOW_ADDR = 11'h030;
    localparam logic [10:0] CRA_ID_HIGH_ADDR = 11'h031;
    localparam logic [10:0] CRA_PINCFG_ADDR = 11'h040;
    localparam logic [10:0] CRA_PINSR_ADDR = 11'h041;
    localparam logic [10:0] CRA_INTSUM_ADDR = 11'h042;
    localparam logic [10:0] CRA_GLOB_ADDR = 11'h043;
    localparam logic [10:0] CRA_ICSUM_ADDR = 11'h044;
    localparam logic [10:0] CRA_OCSUM_ADDR = 11'h045;
    localparam logic [10:0] CRA_ASUM_ADDR = 11'h046;
    localparam logic [10:0] CRA_DSUM_ADDR = 11'h047;
    localparam logic [10:0] CRA_ALOCK_ADDR = 11'h048;
    localparam logic [10:0] CRA_PRIO1_ADDR = 11'h049;
    localparam logic [10:0] CRA_PRIO2_ADDR = 11'h04A;
    localparam logic [10:0] CRA_MSR1_ADDR = 11'h04B;
    localparam logic [10:0] CRA_MSR2_ADDR = 11'h04C;
    localparam logic [10:0] CRA_PADJ_ADDR = 11'h04D;
    // Multibyte field bases, lowest byte first
    localparam logic [10:0] CRA_FZ_BASE = 11'h020;
    localparam logic [10:0] CRA_PH_BASE = 11'h025;
    localparam logic [10:0] CRA_MF_BASE = 11'h065;
    localparam logic [10:0] CRA_PS_BASE = 11'h07D;
    localparam logic [10:0] CRA_FZ_SPAN = 11'h004;
    localparam logic [10:0] CRA_W32_SPAN = 11'h003;
    localparam logic [2:0] CRA_FZ_LAST = 3'h4;
    localparam logic [2:0] CRA_W32_LAST = 3'h3;
    // Multibyte field codes
    localparam logic [2:0] CRA_MB_NONE = 3'h0;
    localparam logic [2:0] CRA_MB_FZ = 3'h1;
    localparam logic [2:0] CRA_MB_PH = 3'h2;
    localparam logic [2:0] CRA_MB_MF = 3'h3;
    localparam logic [2:0] CRA_MB_PS = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int CRA_LAT_ALK = 0;
    localparam int CRA_LAT_ALK2 = 1;
    localparam int CRA_LAT_RDY = 2;
    localparam int CRA_LAT_ADJ = 3;
    localparam int CRA_INTIE_BIT = 1;
    localparam logic [7:0] CRA_CFG_RST = 8'h00;
    localparam logic [3:0] CRA_IE_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        CRA_SP_HI = 3'b001,
        CRA_SP_LO = 3'b010,
        CRA_SP_DATA = 3'b100
    } cra_sp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [10:0] addr;
        logic [7:0] wdata;
    } cra_req_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [10:0] addr;
        logic [7:0] wdata;
    } cra_ee_t;

    typedef struct packed {
        logic [7:0] cfg_pins;
        logic [3:0] pin_levels;
        logic [4:0] int_src;
        logic [7:0] glob;
        logic [2:0] ic_sum;
        logic [2:0] oc_sum;
        logic apll_sum;
        logic dpll_sum;
        logic alk;
        logic alk2;
        logic adlk;
        logic [7:0] prio1;
        logic [7:0] prio2;
        logic meas_ovfl;
        logic meas_busy;
        logic [10:0] meas;
        logic pa_busy;
        logic pa_armed;
        logic [3:0] ev;
        logic [31:0] meas_measured_frequency_word;
        logic [31:0] phase;
    } cra_stat_t;

    typedef struct packed {
        logic [2:0] id;
        logic [2:0] idx;
    } cra_mb_t;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [2:0] mosi_s;
        cra_sp_t ph;
        logic [2:0] cnt;
        logic [6:0] sh_in;
        logic is_rd;
        logic [10:0] addr;
        logic [7:0] sh_out;
        logic load;
        logic oe;
        cra_req_t req;
    } cra_spi_t;

    typedef struct packed {
        logic bank;
        logic [16:0][7:0] cfg;
        logic intie;
        logic [3:0] ie;
        logic [3:0] lat;
        logic [39:0] fword;
        logic [31:0] pword;
        logic [39:0] wr_hold;
        logic [39:0] rd_hold;
        logic [7:0] rdata;
        logic ee_pend;
        cra_ee_t ee;
    } cra_reg_t;

endpackage

// ### rtl/cra_spi_port.sv
// Purpose: serial host port, mode 0, turned into byte accesses
// Assumes: sclk at most clk/12; header is two bytes then data bytes
// Notes: address auto-increments after each data byte
`timescale 1ns/10ps
module cra_spi_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Register side
    input wire logic [7:0] rdata,
    output cra_pkg::cra_req_t req
);
    import cra_pkg::*;

    cra_spi_t s_q, s_d;
    logic rise, fall;
    logic [7:0] byte_in;

    ////////////////////////////////////////////////////////////////////////
    // Pins pass two flops; edges come from the second and third stages
    always_comb begin
        s_d = s_q;
        s_d.cs_s = {s_q.cs_s[1:0], spi_cs_n};
        s_d.sck_s = {s_q.sck_s[1:0], spi_sclk};
        s_d.mosi_s = {s_q.mosi_s[1:0], spi_mosi};
        rise = s_q.sck_s[1] & ~s_q.sck_s[2];
        fall = ~s_q.sck_s[1] & s_q.sck_s[2];
        byte_in = {s_q.sh_in, s_q.mosi_s[1]};
        s_d.req = '0;
        if (s_q.cs_s[1]) begin
            s_d.ph = CRA_SP_HI;
            s_d.cnt = 3'h0;
            s_d.oe = 1'b0;
            s_d.load = 1'b0;
        end else if (rise) begin
            s_d.sh_in = byte_in[6:0];
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.cnt == 3'h7) begin
                case (s_q.ph)
                    CRA_SP_HI: begin
                        s_d.is_rd = byte_in[7];
                        s_d.addr = {byte_in[2:0], 8'h00};
                        s_d.ph = CRA_SP_LO;
                    end
                    CRA_SP_LO: begin
                        s_d.addr = {s_q.addr[10:8], byte_in};
                        s_d.ph = CRA_SP_DATA;
                        s_d.req.rd = s_q.is_rd;
                        s_d.req.addr = {s_q.addr[10:8], byte_in};
                        s_d.load = s_q.is_rd;
                    end
                    CRA_SP_DATA: begin
                        // Reads prefetch the next byte; writes post this one
                        s_d.addr = s_q.addr + 11'h001;
                        s_d.req.rd = s_q.is_rd;
                        s_d.req.wr = ~s_q.is_rd;
                        s_d.req.addr = s_q.is_rd ? s_q.addr + 11'h001
                                                 : s_q.addr;
                        s_d.req.wdata = byte_in;
                        s_d.load = s_q.is_rd;
                    end
                    default: s_d.ph = CRA_SP_HI;
                endcase
            end
        end else if (fall) begin
            // Answer is ready several clocks before this edge
            if (s_q.load) begin
                s_d.sh_out = rdata;
                s_d.load = 1'b0;
                s_d.oe = 1'b1;
            end else begin
                s_d.sh_out = {s_q.sh_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.cs_s <= 3'h7;
            s_q.ph <= CRA_SP_HI;
        end else begin
            s_q <= s_d;
        end
    end

    assign spi_miso = s_q.sh_out[7];
    assign spi_miso_oe = s_q.oe;
    assign req = s_q.req;

endmodule

// ### tb/cra_host_model.sv
// Purpose: system processor model on the serial host port
// Assumes: mode 0, eight clk cycles per sclk half period
// Notes: one frame per byte access; sclk idle low outside frames
`timescale 1ns/10ps
module cra_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    ////////////////////////////////////////
    // Pins idle: no frame, clock still
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // Bits change at clk fall with sclk low; miso is read before the rise
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            repeat (8) @(negedge clk);
            rx[i] = miso;
            sclk = 1'b1;
            repeat (8) @(negedge clk);
            sclk = 1'b0;
        end
    endtask

    // Whole frames only, so two accesses never interleave
    task automatic access(input logic rd, input logic [10:0] a,
            input logic [7:0] wd, output logic [7:0] rv);
        logic [7:0] junk;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (8) @(negedge clk);
        shift({rd, 4'h0, a[10:8]}, junk);
        shift(a[7:0], junk);
        shift(wd, rv);
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi;  // No stale level once released
        repeat (8) @(negedge clk);
    endtask
endmodule

// ### tb/cra_channel_regs_tb_top.sv
// Purpose: self-checking bench of the channel register bank
// Assumes: host model frames; EEPROM answers at the next clk fall
// Notes: the measured word is driven directly on the status input
`timescale 1ns/10ps
module cra_channel_regs_tb_top;
    import cra_pkg::*;
    logic clk, rst, sclk, cs_n, mosi, miso, bank, oe;
    logic [7:0] ee_rdata, rv;
    logic [18:0] ee_wr;
    cra_ee_t ee;
    cra_stat_t st;
    logic [16:0][7:0] cfg;
    logic [39:0] fz;
    logic [31:0] ph;
    int err_total, num_checks;
    int oe_cnt = 0;

    cra_channel_regs uut (.clk(clk), .rst(rst), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
        .spi_miso_oe(oe), .ee_rdata(ee_rdata), .ee(ee), .st(st),
        .bank_select_bit(bank), .cfg_regs(cfg),
        .writable_frequency_word(fz), .phase_offset_word(ph));
    cra_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso));

    ////////////////////////////////////////
    // EEPROM stand-in: data tracks the address, writes are recorded
    always @(negedge clk) ee_rdata <= ee.addr[7:0] ^ 8'hA5;
    always @(posedge clk) if (ee.we === 1'b1) ee_wr <= {ee.addr, ee.wdata};
    // Clocks in which the device drives miso
    always @(posedge clk) if (oe === 1'b1) oe_cnt <= oe_cnt + 1;

    task automatic check(input string nm, input logic [39:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        host.access(1'b0, a, d, rv);
    endtask

    task automatic rdc(input logic [10:0] a, input logic [7:0] e);
        int n;
        n = oe_cnt;
        host.access(1'b1, a, 8'h00, rv);
        check($sformatf("rd %h", a), 40'(rv), 40'(e));
        check("oe read", 40'(oe_cnt > n), 40'h1);
        check("oe idle", 40'(oe), 40'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog: a hung frame still ends in the verdict
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        st = '0;
        ee_rdata = 8'h00;
        ee_wr = '0;
        err_total = 0;
        num_checks = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rdc(CRA_BANK_ADDR, 8'h00);
        wr(CRA_CFG_ADDR[2], 8'h11);
        rdc(CRA_CFG_ADDR[2], 8'h11);
        check("cfg out", 40'(cfg[2]), 40'h11);
        wr(11'h003, 8'hFF);
        rdc(11'h003, 8'h00);
        rdc(11'h603, 8'h00);
        wr(CRA_ID_LOW_ADDR, 8'hFF);
        rdc(CRA_ID_LOW_ADDR, 8'h5A);
        // Lower bytes park; a snapshot read between must not lose them
        for (int i = 0; i < 4; i++) begin
            wr(CRA_FZ_BASE + 11'(i), 8'h10 + 8'(i));
        end
        check("fz held", fz, 40'h0);
        rdc(CRA_FZ_BASE, 8'h00);
        wr(CRA_FZ_BASE + CRA_FZ_SPAN, 8'h14);
        check("fz commit", fz, 40'h14_1312_1110);
        // Write landing inside a read sequence
        rdc(CRA_FZ_BASE, 8'h10);
        wr(CRA_FZ_BASE + 11'h002, 8'h77);
        rdc(CRA_FZ_BASE + 11'h001, 8'h11);
        rdc(CRA_FZ_BASE + 11'h002, 8'h77);
        check("fz kept", fz, 40'h14_1312_1110);
        // Snapshot survives a live change of the measured word
        st.meas_measured_frequency_word = 32'h4433_2211;
        rdc(CRA_MF_BASE, 8'h11);
        st.meas_measured_frequency_word = 32'hDDCC_BBAA;
        rdc(CRA_MF_BASE + 11'h001, 8'h22);
        rdc(CRA_MF_BASE, 8'hAA);
        // Phase offset written while a phase read sequence is open
        st.phase = 32'h8877_6655;
        rdc(CRA_PS_BASE, 8'h55);
        for (int i = 0; i < 4; i++) begin
            wr(CRA_PH_BASE + 11'(i), 8'hC0 + 8'(i));
        end
        check("ph commit", 40'(ph), 40'hC3C2_C1C0);
        rdc(CRA_PS_BASE + 11'h001, 8'hC1);
        // EEPROM bank above address zero
        wr(CRA_BANK_ADDR, 8'h01);
        check("bank", 40'(bank), 40'h1);
        rdc(CRA_CFG_ADDR[0], CRA_CFG_ADDR[0][7:0] ^ 8'hA5);
        wr(CRA_CFG_ADDR[0], 8'h3C);
        check("ee wr", 40'(ee_wr), 40'({CRA_CFG_ADDR[0], 8'h3C}));
        rdc(CRA_BANK_ADDR, 8'h01);
        wr(CRA_BANK_ADDR, 8'h00);
        rdc(CRA_CFG_ADDR[0], 8'h00);
        // Latched lock-loss bit: a written zero keeps it, a one clears it
        @(negedge clk) st.ev[CRA_LAT_ALK] = 1'b1;
        @(negedge clk) st.ev[CRA_LAT_ALK] = 1'b0;
        rdc(CRA_ALOCK_ADDR, 8'h02);
        wr(CRA_ALOCK_ADDR, 8'h00);
        rdc(CRA_ALOCK_ADDR, 8'h02);
        wr(CRA_ALOCK_ADDR, 8'h02);
        rdc(CRA_ALOCK_ADDR, 8'h00);
        final_report();
    end
endmodule
